// >>> verilog/oxy_pkg.sv
// Package: constants and types for the oxygen alarm/output control block.
// Assumes the concentration arrives as signed hundredths of a vol%.
package oxy_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned ALARM_DELAY_S = 2;
  localparam int unsigned ALARM_DELAY_CYC = ALARM_DELAY_S * CLK_HZ;
  localparam int unsigned ALT_PERIOD_MS = 1000;
  localparam int unsigned ALT_PERIOD_CYC = ALT_PERIOD_MS * (CLK_HZ / 1000);

  // ----------------------------------------
  // Concentration scale, 0.01 vol% units
  // ----------------------------------------
  localparam int CONC_W = 16;
  localparam logic signed [15:0] FULL_SCALE = 16'sh09C4;
  localparam logic signed [15:0] NOMINAL_AIR = 16'sh082A;
  localparam logic signed [15:0] SUPPRESS_BAND_RST = 16'sh0032;
  localparam logic signed [15:0] NEG_BAND = 16'sh00FA;

  // ----------------------------------------
  // Loop current codes, 0.01 mA units
  // ----------------------------------------
  localparam logic [15:0] LOOP_4MA = 16'h0190;
  localparam logic [15:0] LOOP_SPAN = 16'h0640;
  localparam logic [15:0] LOOP_20P5MA = 16'h0802;
  localparam logic [15:0] LOOP_21P5MA = 16'h0866;
  localparam logic [15:0] LOOP_0P5MA = 16'h0032;

  // ----------------------------------------
  // Display selection
  // ----------------------------------------
  typedef enum logic [2:0] {
    DISP_CONC = 3'b000,
    DISP_OVER = 3'b001,
    DISP_WARN = 3'b010,
    DISP_FAULT = 3'b011,
    DISP_NEG_ZERO = 3'b100
  } disp_sel_t;

  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_DETECT = 3'b000,
    MODE_USER = 3'b001,
    MODE_MAINT = 3'b010,
    MODE_ALARM_TEST = 3'b011,
    MODE_INHIBIT = 3'b100
  } op_mode_t;

  typedef enum logic [1:0] {
    ST_INIT_CLEAR = 2'b00,
    ST_RUN = 2'b01,
    ST_FAULT = 2'b10
  } run_state_t;

endpackage

// >>> verilog/loop_if.sv
// Interface: carries the reading and the scaled loop current between modules.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface loop_if;
  import oxy_pkg::*;
  logic signed [15:0] conc;
  logic [15:0] loop_code;
  modport scaler (input conc, output loop_code);
  modport user (output conc, input loop_code);
endinterface
`default_nettype wire

// >>> verilog/loop_scaler.sv
// Loop scaler: linear map of concentration onto the 4-20 mA span.
// Assumes conc in 0.01 vol%, full scale at FULL_SCALE.
`timescale 1ns/100ps
`default_nettype none
module loop_scaler
  import oxy_pkg::*;
(
  loop_if.scaler lp
);

  logic [31:0] prod;
  logic [15:0] clipped;

  // ----------------------------------------
  // Clamp then scale
  // ----------------------------------------
  always_comb begin
    if (lp.conc < 16'sh0000) begin
      clipped = 16'h0000;
    end else if (lp.conc > FULL_SCALE) begin
      clipped = 16'(FULL_SCALE);
    end else begin
      clipped = 16'(lp.conc);
    end
    prod = (32'(clipped) * 32'(LOOP_SPAN)) / 32'(FULL_SCALE);
    lp.loop_code = 16'(prod[15:0] + LOOP_4MA);
  end

endmodule
`default_nettype wire

// >>> verilog/oxy_alarm_ctrl.sv
// Top: alarm latch, lamps, display selection and loop current choice.
// Assumes conc is a sampled reading on mclk; keys and pins synchronised here.
//
// Functional notes
// - Alarm and red lamp at or below setpoint
// - Alarm stays latched after recovery
// - Only key press clears latched alarm
// - Two-second alarm delay, can be disabled
// - Over-range shows over-scale pattern
// - Green power lamp steadily on
// - Fault: yellow lamp, fault message shown
// - Fault recovery reruns initial clear
// - Over-temperature alternates reading and warning code
// - Maintenance, init, inhibit drive fixed level
// - Fault drives fixed 0.5 mA
// - Above full scale drives 20.5 mA max
// - Normal states drive proportional 4-20 mA
// - Alarm test: proportional or fixed 4 mA
// - Inhibit/init level from maintenance setting
// - Suppress band around 20.9 outside maintenance
// - Maintenance shows unsuppressed reading
// - Negative readings suppressed; deep ones show -0.0
`timescale 1ns/100ps
`default_nettype none
module oxy_alarm_ctrl
  import oxy_pkg::*;
#(
  parameter int unsigned ALARM_DELAY = ALARM_DELAY_CYC,
  parameter int unsigned ALT_PERIOD = ALT_PERIOD_CYC,
  parameter int unsigned INIT_CYC = 1000
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic signed [15:0] conc,
  input wire logic conc_valid,
  input wire logic signed [15:0] alarm_setpoint,
  input wire logic alarm_enable,
  input wire logic alarm_delay_enable,
  input wire logic signed [15:0] suppress_band,
  input wire logic [2:0] op_mode,
  input wire logic test_output_on,
  input wire logic [15:0] maint_output_code,
  input wire logic fault_detect,
  input wire logic [7:0] fault_code_in,
  input wire logic temp_out_of_range,
  input wire logic reset_key,
  output logic power_lamp,
  output logic alarm_lamp,
  output logic fault_lamp,
  output logic alarm_active,
  output logic [2:0] disp_sel,
  output logic signed [15:0] disp_value,
  output logic [7:0] fault_code,
  output logic [15:0] loop_code,
  output logic init_active
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] key_sync;
  logic [1:0] fault_sync;
  logic [1:0] temp_sync;
  logic key_prev;
  logic key_press;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      key_sync <= 2'b00;
      fault_sync <= 2'b00;
      temp_sync <= 2'b00;
    end else begin
      key_sync <= {key_sync[0], reset_key};
      fault_sync <= {fault_sync[0], fault_detect};
      temp_sync <= {temp_sync[0], temp_out_of_range};
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      key_prev <= 1'b0;
    end else begin
      key_prev <= key_sync[1];
    end
  end

  assign key_press = key_sync[1] & ~key_prev;

  // ----------------------------------------
  // Run state: initial clear, run, fault
  // ----------------------------------------
  run_state_t state;
  run_state_t next_state;
  logic [31:0] init_cnt;
  logic init_done;

  assign init_done = (init_cnt >= INIT_CYC - 1);

  always_comb begin
    next_state = state;
    case (state)
      ST_INIT_CLEAR: begin
        if (fault_sync[1]) begin
          next_state = ST_FAULT;
        end else if (init_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fault_sync[1]) begin
          next_state = ST_FAULT;
        end
      end
      ST_FAULT: begin
        if (!fault_sync[1]) begin
          next_state = ST_INIT_CLEAR;
        end
      end
      default: begin
        next_state = ST_INIT_CLEAR;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_INIT_CLEAR;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      init_cnt <= 32'h0000_0000;
    end else if (state != ST_INIT_CLEAR) begin
      init_cnt <= 32'h0000_0000;
    end else if (!init_done) begin
      init_cnt <= init_cnt + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // Alarm qualification and latch
  // ----------------------------------------
  logic below_set;
  logic [31:0] delay_cnt;
  logic delay_done;
  logic alarm_latch;

  // Comparison uses the raw reading so suppression never hides a real low
  assign below_set = alarm_enable && conc_valid && (conc <= alarm_setpoint);
  assign delay_done = !alarm_delay_enable || (delay_cnt >= ALARM_DELAY - 1);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      delay_cnt <= 32'h0000_0000;
    end else if (!below_set || state != ST_RUN) begin
      delay_cnt <= 32'h0000_0000;
    end else if (!delay_done) begin
      delay_cnt <= delay_cnt + 32'h0000_0001;
    end
  end

  // Set wins over a key press in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_latch <= 1'b0;
    end else if (state == ST_RUN && below_set && delay_done) begin
      alarm_latch <= 1'b1;
    end else if (key_press) begin
      alarm_latch <= 1'b0;
    end else begin
      alarm_latch <= alarm_latch;
    end
  end

  // ----------------------------------------
  // Lamps and fault code
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      power_lamp <= 1'b0;
      alarm_lamp <= 1'b0;
      fault_lamp <= 1'b0;
      alarm_active <= 1'b0;
      fault_code <= 8'h00;
      init_active <= 1'b1;
    end else begin
      power_lamp <= 1'b1;
      alarm_lamp <= alarm_latch;
      alarm_active <= alarm_latch;
      fault_lamp <= (state == ST_FAULT);
      fault_code <= (state == ST_FAULT) ? fault_code_in : 8'h00;
      init_active <= (state == ST_INIT_CLEAR);
    end
  end

  // ----------------------------------------
  // Warning alternation tick
  // ----------------------------------------
  logic [31:0] alt_cnt;
  logic alt_phase;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      alt_cnt <= 32'h0000_0000;
      alt_phase <= 1'b0;
    end else if (!temp_sync[1]) begin
      alt_cnt <= 32'h0000_0000;
      alt_phase <= 1'b0;
    end else if (alt_cnt >= ALT_PERIOD - 1) begin
      alt_cnt <= 32'h0000_0000;
      alt_phase <= ~alt_phase;
    end else begin
      alt_cnt <= alt_cnt + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // Reading suppression
  // ----------------------------------------
  function automatic logic signed [15:0] abs16(input logic signed [15:0] v);
    abs16 = (v < 16'sh0000) ? 16'(-v) : v;
  endfunction

  logic maint;
  logic signed [15:0] shown;
  logic deep_neg;
  logic over_scale;

  assign maint = (op_mode == MODE_MAINT);
  assign over_scale = (conc > FULL_SCALE);
  assign deep_neg = (conc < 16'sh0000) && (abs16(conc) >= NEG_BAND);

  always_comb begin
    shown = conc;
    if (!maint) begin
      if (abs16(16'(conc - NOMINAL_AIR)) <= suppress_band) begin
        shown = NOMINAL_AIR;
      end else if (conc < 16'sh0000) begin
        shown = 16'sh0000;
      end
    end
  end

  // ----------------------------------------
  // Display selection
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      disp_sel <= DISP_CONC;
      disp_value <= 16'sh0000;
    end else begin
      disp_value <= shown;
      if (state == ST_FAULT) begin
        disp_sel <= DISP_FAULT;
      end else if (over_scale) begin
        disp_sel <= DISP_OVER;
      end else if (deep_neg) begin
        disp_sel <= DISP_NEG_ZERO;
      end else if (temp_sync[1] && alt_phase) begin
        disp_sel <= DISP_WARN;
      end else begin
        disp_sel <= DISP_CONC;
      end
    end
  end

  // ----------------------------------------
  // Loop current selection
  // ----------------------------------------
  loop_if lp ();
  loop_scaler u_scaler (
    .lp(lp.scaler)
  );
  assign lp.conc = conc;

  logic [15:0] next_loop;

  always_comb begin
    next_loop = lp.loop_code;
    if (state == ST_FAULT) begin
      next_loop = LOOP_0P5MA;
    end else if (state == ST_INIT_CLEAR || op_mode == MODE_INHIBIT) begin
      next_loop = maint_output_code;
    end else if (maint) begin
      next_loop = LOOP_21P5MA;
    end else if (op_mode == MODE_ALARM_TEST && !test_output_on) begin
      next_loop = LOOP_4MA;
    end else if (over_scale) begin
      next_loop = LOOP_20P5MA;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      loop_code <= LOOP_21P5MA;
    end else begin
      loop_code <= next_loop;
    end
  end

endmodule
`default_nettype wire

// >>> test/oxy_alarm_ctrl_sva.sv
// Checker: port-level timing relations of oxy_alarm_ctrl.
// Assumes configuration inputs are held steady between test phases.
`timescale 1ns/100ps
`default_nettype none
module oxy_alarm_ctrl_sva
  import oxy_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic signed [15:0] conc,
  input wire logic conc_valid,
  input wire logic signed [15:0] alarm_setpoint,
  input wire logic alarm_enable,
  input wire logic alarm_delay_enable,
  input wire logic [2:0] op_mode,
  input wire logic [15:0] maint_output_code,
  input wire logic reset_key,
  input wire logic power_lamp,
  input wire logic alarm_lamp,
  input wire logic fault_lamp,
  input wire logic alarm_active,
  input wire logic [2:0] disp_sel,
  input wire logic [15:0] loop_code,
  input wire logic init_active
);
  // ----------------------------------------
  // Helpers and properties
  // ----------------------------------------
  // Key history: the clear lands several edges after the key
  logic [5:0] key_hist;
  logic below;
  assign below = alarm_enable && conc_valid && conc <= alarm_setpoint;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      key_hist <= '0;
    end else begin
      key_hist <= {key_hist[4:0], reset_key};
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_run;
    !fault_lamp && !init_active ##1 !fault_lamp && !init_active;
  endsequence
  chk_power_steady: assert property ($past(rst_b) |-> power_lamp) else $error("power lamp off");
  chk_lamp_follows: assert property (alarm_lamp == alarm_active) else $error("alarm lamp mismatch");
  chk_alarm_now: assert property (s_run ##0 (below && !alarm_delay_enable && op_mode == MODE_DETECT
    && key_hist == '0 && !reset_key) |-> ##[1:3] alarm_active) else $error("alarm not raised");
  chk_alarm_delay: assert property ($rose(alarm_active) && alarm_delay_enable && $past(alarm_delay_enable, 8)
    |-> $past(below, 8)) else $error("alarm raised early");
  chk_alarm_latch: assert property ($fell(alarm_active) && !fault_lamp && !$past(fault_lamp) && !init_active
    |-> key_hist != '0) else $error("alarm dropped without key");
  chk_fault_loop: assert property (fault_lamp && $past(fault_lamp)
    |-> loop_code == LOOP_0P5MA && disp_sel == DISP_FAULT) else $error("fault output wrong");
  chk_init_loop: assert property ($past(rst_b) && $past(init_active) && init_active && !fault_lamp
    |-> loop_code == maint_output_code) else $error("init loop wrong");
  chk_maint_loop: assert property (s_run ##0 (op_mode == MODE_MAINT && $past(op_mode) == MODE_MAINT)
    |-> loop_code == LOOP_21P5MA) else $error("maint loop wrong");
  chk_over_cap: assert property (s_run ##0 (op_mode == MODE_DETECT && $past(op_mode) == MODE_DETECT)
    |-> loop_code <= LOOP_20P5MA) else $error("loop above cap");
  chk_fault_restart: assert property ($fell(fault_lamp) |-> ##[0:2] init_active) else $error("no restart");
endmodule
bind oxy_alarm_ctrl oxy_alarm_ctrl_sva i_oxy_alarm_ctrl_sva (.mclk, .rst_b, .conc, .conc_valid, .alarm_setpoint,
  .alarm_enable, .alarm_delay_enable, .op_mode, .maint_output_code, .reset_key, .power_lamp, .alarm_lamp,
  .fault_lamp, .alarm_active, .disp_sel, .loop_code, .init_active);
`default_nettype wire

// >>> test/loop_monitor.sv
// Partner: central receiver model, sorts the loop current into bands.
// Assumes loop_code in 0.01 mA on the design clock.
`timescale 1ns/100ps
`default_nettype none
module loop_monitor
  import oxy_pkg::*;
(
  input wire logic mclk,
  input wire logic [15:0] loop_code,
  output logic [1:0] loop_class
);
  // Band 0 fault, 1 live reading, 2 over-scale, 3 fixed high
  always_ff @(posedge mclk) begin
    if (loop_code < LOOP_4MA) begin
      loop_class <= 2'h0;
    end else if (loop_code <= LOOP_4MA + LOOP_SPAN) begin
      loop_class <= 2'h1;
    end else if (loop_code <= LOOP_20P5MA) begin
      loop_class <= 2'h2;
    end else begin
      loop_class <= 2'h3;
    end
  end
endmodule
`default_nettype wire

// >>> test/oxy_alarm_ctrl_bench.sv
// Bench: drives oxy_alarm_ctrl with short counts, checks queued notes.
// Assumes oxy_pkg, the checker and loop_monitor are compiled first.
`timescale 1ns/100ps
`default_nettype none
module oxy_alarm_ctrl_bench
  import oxy_pkg::*;
;
  typedef struct {int k; logic [15:0] v;} note_t;
  // Alarm off until its own scenario, so low loop points cannot latch it early
  logic mclk = 1'b0, rst_b = 1'b0, conc_valid = 1'b1, alarm_enable = 1'b0, alarm_delay_enable = 1'b0;
  logic signed [15:0] conc = NOMINAL_AIR, alarm_setpoint = 16'sh0708, suppress_band = SUPPRESS_BAND_RST;
  logic [2:0] op_mode = MODE_DETECT;
  logic test_output_on = 1'b0, fault_detect = 1'b0, temp_out_of_range = 1'b0, reset_key = 1'b0;
  logic [15:0] maint_output_code = 16'h0123;
  logic [7:0] fault_code_in = 8'h5A;
  logic power_lamp, alarm_lamp, fault_lamp, alarm_active, init_active, warn_seen;
  logic [2:0] disp_sel;
  logic signed [15:0] disp_value;
  logic [7:0] fault_code;
  logic [15:0] loop_code;
  logic [1:0] loop_class;
  int errors = 0, n_tests = 0, r;
  note_t q[$], n;
  event chk_ev;
  string nm[10] = '{"loop", "disp_sel", "disp_value", "alarm", "fault_lamp", "power", "init", "fault_code",
    "loop_class", "warn"};
  logic signed [15:0] cv[4] = '{16'sh0000, 16'sh04E2, 16'sh09C4, 16'sh0A28};
  logic [15:0] lv[4] = '{16'h0190, 16'h04B0, 16'h07D0, 16'h0802};
  oxy_alarm_ctrl #(.ALARM_DELAY(10), .ALT_PERIOD(8), .INIT_CYC(5)) i_oxy_alarm_ctrl (.mclk, .rst_b, .conc,
    .conc_valid, .alarm_setpoint, .alarm_enable, .alarm_delay_enable, .suppress_band, .op_mode, .test_output_on,
    .maint_output_code, .fault_detect, .fault_code_in, .temp_out_of_range, .reset_key, .power_lamp, .alarm_lamp,
    .fault_lamp, .alarm_active, .disp_sel, .disp_value, .fault_code, .loop_code, .init_active);
  loop_monitor i_loop_monitor (.mclk, .loop_code, .loop_class);
  always #5 mclk = ~mclk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic step(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic note(input int k, input logic [15:0] v);
    q.push_back('{k, v});
    -> chk_ev;
  endtask
  function automatic logic [15:0] got_of(input int k);
    case (k)
      0: got_of = loop_code;
      1: got_of = {13'h0000, disp_sel};
      2: got_of = disp_value;
      3: got_of = {15'h0000, alarm_lamp};
      4: got_of = {15'h0000, fault_lamp};
      5: got_of = {15'h0000, power_lamp};
      6: got_of = {15'h0000, init_active};
      7: got_of = {8'h00, fault_code};
      8: got_of = {14'h0000, loop_class};
      default: got_of = {15'h0000, warn_seen};
    endcase
  endfunction
  task automatic cmp(input int k, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm[k], e, g);
    end
  endtask
  task automatic press_key;
    reset_key = 1'b1;
    step(3);
    reset_key = 1'b0;
    step(6);
  endtask
  task automatic close_out;
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Monitor, watchdog, tests
  // ----------------------------------------
  initial forever begin
    @(chk_ev);
    while (q.size() > 0) begin
      n = q.pop_front();
      cmp(n.k, n.v, got_of(n.k));
    end
  end
  initial begin
    #100us;
    errors++;
    close_out();
  end
  initial begin
    r = $urandom(7774);
    step(8);
    rst_b = 1'b1;
    step(2);
    note(6, 16'h0001);
    note(0, maint_output_code);
    step(8);
    note(5, 16'h0001);
    conc = NOMINAL_AIR - 16'sh0032 + 16'($urandom_range(100));
    step(3);
    note(2, NOMINAL_AIR);
    op_mode = MODE_MAINT;
    conc = 16'sh0834;
    step(3);
    note(0, LOOP_21P5MA);
    note(2, 16'h0834);
    note(8, 16'h0003);
    op_mode = MODE_DETECT;
    for (int i = 0; i < 4; i++) begin
      conc = cv[i];
      step(3);
      note(0, lv[i]);
      note(1, (i == 3) ? 16'h0001 : 16'h0000);
    end
    note(8, 16'h0002);
    conc = 16'shFF9C;
    step(3);
    note(2, 16'h0000);
    conc = 16'shFF06;
    step(3);
    note(1, 16'h0004);
    op_mode = MODE_ALARM_TEST;
    conc = 16'sh04E2;
    step(3);
    note(0, LOOP_4MA);
    test_output_on = 1'b1;
    step(3);
    note(0, 16'h04B0);
    op_mode = MODE_INHIBIT;
    step(3);
    note(0, maint_output_code);
    op_mode = MODE_DETECT;
    alarm_enable = 1'b1;
    conc = 16'sh06A4;
    step(4);
    note(3, 16'h0001);
    conc = NOMINAL_AIR;
    step(3);
    note(3, 16'h0001);
    press_key();
    note(3, 16'h0000);
    alarm_delay_enable = 1'b1;
    conc = alarm_setpoint;
    step(6);
    note(3, 16'h0000);
    step(8);
    note(3, 16'h0001);
    conc = NOMINAL_AIR;
    press_key();
    note(3, 16'h0000);
    temp_out_of_range = 1'b1;
    conc = 16'sh04E2;
    warn_seen = 1'b0;
    repeat (24) begin
      step(1);
      warn_seen = warn_seen | (disp_sel === DISP_WARN);
    end
    note(9, 16'h0001);
    note(4, 16'h0000);
    note(0, 16'h04B0);
    temp_out_of_range = 1'b0;
    fault_detect = 1'b1;
    step(5);
    note(4, 16'h0001);
    note(0, LOOP_0P5MA);
    note(1, 16'h0003);
    note(7, 16'h005A);
    note(8, 16'h0000);
    fault_detect = 1'b0;
    step(4);
    note(6, 16'h0001);
    note(0, maint_output_code);
    step(8);
    close_out();
  end
endmodule
`default_nettype wire
